// ### src/ppc_pkg.sv
package ppc_pkg;
   // Port register map, word offsets on the plain register port
   localparam logic [3:0] ADDR_DIR = 4'h0;
   localparam logic [3:0] ADDR_OUT = 4'h1;
   localparam logic [3:0] ADDR_PIN = 4'h2;
   localparam logic [3:0] ADDR_CTL = 4'h3;
   // Control register field
   localparam int CTL_PUD_BIT = 0;
   // Reset values
   localparam logic RST_DIR = 1'b0;
   localparam logic RST_OUT = 1'b0;
   localparam logic RST_PUD = 1'b0;
   // Address width of the register port
   localparam int ADDR_W = 4;

   // Override bundle driven by alternate-function modules, one bit a pin
   typedef struct packed {
      logic pu_en;
      logic pu_val;
      logic dir_en;
      logic dir_val;
      logic pv_en;
      logic pv_val;
      logic tog_en;
      logic die_en;
      logic die_val;
   } ppc_ovr_t;

   // Pad drive bundle for one pin
   typedef struct packed {
      logic drive_oe;
      logic drive_val;
      logic pullup_en;
   } ppc_pad_t;
endpackage

// ### src/ppc_port.sv
// Operation
// [RL1] Pull-up on only for input, out bit one, global disable clear
// [RL2] Output mode drives out bit level; pull-up off
// [RL3] Software passes via pull-up input or output low between Hi-Z and high
// [RL4] Software passes via Hi-Z or output high between pull-up and low
// [RL5] Synchronized pin level readable whatever the direction
// [RL6] Latch transparent while clock high, loads pin bit on rising edge
// [RL7] Pin transition reaches pin bit in half to one and half periods
// [RL8] Written output value readable after one clock; software waits one; here pad_o_out is registered: two clocks, software waits two
// [RL9] Deep sleep clamps digital input to ground
// [RL10] Clamp skipped for pins with external interrupt enabled
// [RL11] High pin during clamped sleep gives interrupt flag on wake
// [RL12] Pull-up override enable makes pull-up follow override value
// [RL13] Direction override enable makes driver follow override value
// [RL14] Port value override replaces out bit while driving
// [RL15] Toggle override inverts the out bit
// [RL16] Input enable override sets input enable regardless of sleep
// [RL17] Alternate digital input taken before synchronizer
// [RL18] Analog path connects straight to the pad; here the pad level is registered, one clock late
// [RL19] Pull-ups held off during reset
// [RL20] Writing one to pin bit toggles the out bit
// [RL21] All pins tri-stated while reset active
// [RL22] Direction and out bits reset to zero
//
// Our own choices: the address-and-strobe port and the placing of the registers.
module ppc_port #(
   parameter int WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic rst_n_in,
   input wire logic [ppc_pkg::ADDR_W-1:0] addr_in,
   input wire logic [WIDTH-1:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [WIDTH-1:0] rdata_out,
   input wire logic [WIDTH-1:0] pad_level_in,
   input wire logic sleep_clamp_in,
   input wire logic [WIDTH-1:0] ext_irq_en_in,
   input wire ppc_pkg::ppc_ovr_t [WIDTH-1:0] ovr_in,
   output logic [WIDTH-1:0] pad_oe_out,
   output logic [WIDTH-1:0] pad_o_out,
   output logic [WIDTH-1:0] pad_pullup_out,
   output logic [WIDTH-1:0] alt_function_digital_input_out,
   output logic [WIDTH-1:0] alt_function_analog_io_out
);

   logic [WIDTH-1:0] pin_direction_bit_r;
   logic [WIDTH-1:0] pin_out_value_bit_r;
   logic [WIDTH-1:0] pin_out_value_bit_nxt;
   logic [WIDTH-1:0] pin_input_sync_bit_r;
   logic [WIDTH-1:0] sync_stage_r;
   logic global_pullup_disable_r;
   logic [WIDTH-1:0] din_gated;
   logic [WIDTH-1:0] drv_oe_nxt;
   logic [WIDTH-1:0] drv_val_nxt;
   logic [WIDTH-1:0] pu_nxt;
   logic [WIDTH-1:0] ie;
   // Toggle mask, read mux and decoded register strobes
   logic [WIDTH-1:0] tog_mask;
   logic [WIDTH-1:0] rdata_nxt;
   logic wr_dir;
   logic wr_out;
   logic wr_pin;
   logic wr_ctl;
   logic rd_dir;
   logic rd_out;
   logic rd_pin;
   logic rd_ctl;

   // Driver enable: direction override first, else direction bit
   function automatic logic drive_enable(
      input logic dir,
      input ppc_pkg::ppc_ovr_t o
   );
      return o.dir_en ? o.dir_val : dir; // RL13
   endfunction

   // Driven level: port-value override first, else out bit
   function automatic logic drive_level(
      input logic outv,
      input ppc_pkg::ppc_ovr_t o
   );
      return o.pv_en ? o.pv_val : outv; // RL14
   endfunction

   // Pull-up: override value if enabled, else input with out bit one and global disable clear
   function automatic logic pullup_on(
      input logic dir,
      input logic outv,
      input logic global_pullup_disable,
      input ppc_pkg::ppc_ovr_t o
   );
      logic pu;
      if (o.pu_en) begin
         pu = o.pu_val; // RL12
      end else begin
         pu = ~dir & outv & ~global_pullup_disable; // RL1 RL2
      end
      return pu;
   endfunction

   // Pad control for one pin from its bits and overrides
   function automatic ppc_pkg::ppc_pad_t pad_ctl(
      input logic dir,
      input logic outv,
      input logic global_pullup_disable,
      input ppc_pkg::ppc_ovr_t o
   );
      ppc_pkg::ppc_pad_t p;
      p.drive_oe = drive_enable(dir, o);
      p.drive_val = drive_level(outv, o);
      p.pullup_en = pullup_on(dir, outv, global_pullup_disable, o);
      return p;
   endfunction

   // Strobe qualified by a word address match
   function automatic logic reg_hit(
      input logic stb,
      input logic [ppc_pkg::ADDR_W-1:0] a,
      input logic [ppc_pkg::ADDR_W-1:0] target
   );
      return stb && (a == target);
   endfunction

   // Digital input enable: override first, then sleep clamp
   function automatic logic in_enable(
      input logic sleep,
      input logic irq_en,
      input ppc_pkg::ppc_ovr_t o
   );
      logic en;
      if (o.die_en) begin
         en = o.die_val; // RL16
      end else begin
         en = ~sleep | irq_en; // RL9 RL10
      end
      return en;
   endfunction

   // Control word as read back, pull-up disable in its field
   function automatic logic [WIDTH-1:0] ctl_word(input logic global_pullup_disable);
      logic [WIDTH-1:0] w;
      w = '0;
      w[ppc_pkg::CTL_PUD_BIT] = global_pullup_disable;
      return w;
   endfunction

   // Register strobes, decoded once for every process
   assign wr_dir = reg_hit(wr_in, addr_in, ppc_pkg::ADDR_DIR);
   assign wr_out = reg_hit(wr_in, addr_in, ppc_pkg::ADDR_OUT);
   assign wr_pin = reg_hit(wr_in, addr_in, ppc_pkg::ADDR_PIN);
   assign wr_ctl = reg_hit(wr_in, addr_in, ppc_pkg::ADDR_CTL);
   assign rd_dir = reg_hit(rd_in, addr_in, ppc_pkg::ADDR_DIR);
   assign rd_out = reg_hit(rd_in, addr_in, ppc_pkg::ADDR_OUT);
   assign rd_pin = reg_hit(rd_in, addr_in, ppc_pkg::ADDR_PIN);
   assign rd_ctl = reg_hit(rd_in, addr_in, ppc_pkg::ADDR_CTL);

   // Per-pin pad control from the bits and overrides
   always_comb begin
      ppc_pkg::ppc_pad_t p;
      p = '0;
      for (int i = 0; i < WIDTH; i++) begin
         p = pad_ctl(pin_direction_bit_r[i], pin_out_value_bit_r[i],
                     global_pullup_disable_r, ovr_in[i]);
         drv_oe_nxt[i] = p.drive_oe;
         drv_val_nxt[i] = p.drive_val;
         pu_nxt[i] = p.pullup_en;
      end
   end

   // Input enable; clamped input reads low, so a high pin wakes on an edge
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         ie[i] = in_enable(sleep_clamp_in, ext_irq_en_in[i], ovr_in[i]);
         din_gated[i] = pad_level_in[i] & ie[i]; // RL11
      end
   end

   // Toggle override mask, one bit a pin
   always_comb begin
      for (int i = 0; i < WIDTH; i++) begin
         tog_mask[i] = ovr_in[i].tog_en; // RL15
      end
   end

   // Out bit next value: software write, pin-bit toggle, toggle override
   always_comb begin
      pin_out_value_bit_nxt = pin_out_value_bit_r;
      if (wr_out) begin
         pin_out_value_bit_nxt = wdata_in;
      end else if (wr_pin) begin
         pin_out_value_bit_nxt = pin_out_value_bit_r ^ wdata_in; // RL20
      end
      // Override toggles after the software update of the same cycle
      pin_out_value_bit_nxt = pin_out_value_bit_nxt ^ tog_mask; // RL15
   end

   // Direction register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_direction_bit_r <= {WIDTH{ppc_pkg::RST_DIR}}; // RL22
      end else if (wr_dir) begin
         pin_direction_bit_r <= wdata_in;
      end
   end

   // Global pull-up disable, shared by every pin
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         global_pullup_disable_r <= ppc_pkg::RST_PUD;
      end else if (wr_ctl) begin
         global_pullup_disable_r <= wdata_in[ppc_pkg::CTL_PUD_BIT];
      end
   end

   // Output value register
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_out_value_bit_r <= {WIDTH{ppc_pkg::RST_OUT}}; // RL22
      end else begin
         pin_out_value_bit_r <= pin_out_value_bit_nxt;
      end
   end

   // Synchronizer; the half-period latch stage is modelled by a falling
   // edge flop, giving a half to one and half period delay
   always_ff @(negedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sync_stage_r <= '0;
      end else begin
         sync_stage_r <= din_gated; // RL6 RL7
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_input_sync_bit_r <= '0;
      end else begin
         pin_input_sync_bit_r <= sync_stage_r; // RL6 RL7 RL8
      end
   end

   // Driver enable, registered; reset tri-states every pin
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pad_oe_out <= '0; // RL21
      end else begin
         pad_oe_out <= drv_oe_nxt; // RL2 RL13
      end
   end

   // Driven level, registered
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pad_o_out <= '0;
      end else begin
         pad_o_out <= drv_val_nxt; // RL2 RL14
      end
   end

   // Pull-up enable, registered; held off while in reset
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pad_pullup_out <= '0; // RL19
      end else begin
         pad_pullup_out <= pu_nxt; // RL1 RL12
      end
   end

   // Alternate-function digital input, unsynchronized path
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         alt_function_digital_input_out <= '0;
      end else begin
         alt_function_digital_input_out <= din_gated; // RL17
      end
   end

   // Alternate-function analog path, raw pad level
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         alt_function_analog_io_out <= '0;
      end else begin
         alt_function_analog_io_out <= pad_level_in; // RL18
      end
   end

   // Read data mux; unmapped words and idle cycles give zero
   always_comb begin
      rdata_nxt = '0;
      if (rd_dir) begin
         rdata_nxt = pin_direction_bit_r;
      end else if (rd_out) begin
         rdata_nxt = pin_out_value_bit_r;
      end else if (rd_pin) begin
         rdata_nxt = pin_input_sync_bit_r; // RL5
      end else if (rd_ctl) begin
         rdata_nxt = ctl_word(global_pullup_disable_r);
      end
   end

   // Read data, one cycle after the read strobe
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= rdata_nxt;
      end
   end

endmodule

// ### test/ppc_port_checker.sv
module ppc_checker #(parameter int WIDTH = 8) (
   input wire logic clk_in, rst_n_in, rd_in, sleep_clamp_in,
   input wire logic [ppc_pkg::ADDR_W-1:0] addr_in,
   input wire logic [WIDTH-1:0] rdata_out, pad_level_in, ext_irq_en_in,
   input wire ppc_pkg::ppc_ovr_t [WIDTH-1:0] ovr_in,
   input wire logic [WIDTH-1:0] pad_oe_out, pad_o_out, pad_pullup_out,
   input wire logic [WIDTH-1:0] alt_function_digital_input_out,
   input wire logic [WIDTH-1:0] alt_function_analog_io_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Pin zero views
   wire ppc_pkg::ppc_ovr_t o = ovr_in[0];
   wire logic di = alt_function_digital_input_out[0];
   wire logic pl = pad_level_in[0];
   wire logic irq = ext_irq_en_in[0];
   sequence s_drv; o.dir_en && o.dir_val && o.pv_en; endsequence
   sequence s_clamp; sleep_clamp_in && !irq && !o.die_en; endsequence
   sequence s_open; rst_n_in && !o.die_en && (!sleep_clamp_in || irq);
   endsequence
   property p_pu; o.pu_en |=> pad_pullup_out[0] == $past(o.pu_val); endproperty
   a_pu: assert property (p_pu) else $error("pull-up override");
   property p_dir; o.dir_en |=> pad_oe_out[0] == $past(o.dir_val); endproperty
   a_dir: assert property (p_dir) else $error("dir override");
   property p_pv; s_drv |=> pad_o_out[0] == $past(o.pv_val); endproperty
   a_pv: assert property (p_pv) else $error("value override");
   property p_clamp; s_clamp |=> !di; endproperty
   a_clamp: assert property (p_clamp) else $error("clamp");
   property p_open; s_open |=> di == $past(pl); endproperty
   a_open: assert property (p_open) else $error("open input");
   property p_die;
      o.die_en |=> di == ($past(o.die_val) && $past(pl));
   endproperty
   a_die: assert property (p_die) else $error("input enable");
   property p_aio;
      rst_n_in |=> alt_function_analog_io_out == $past(pad_level_in);
   endproperty
   a_aio: assert property (p_aio) else $error("analog path");
   property p_rd; (!rd_in || addr_in > 4'h3) |=> rdata_out == '0; endproperty
   a_rd: assert property (p_rd) else $error("idle read data");
endmodule
bind ppc_port ppc_checker #(.WIDTH(WIDTH)) u_ppc_checker (.clk_in, .rst_n_in,
   .rd_in, .sleep_clamp_in, .addr_in, .rdata_out, .pad_level_in,
   .ext_irq_en_in, .ovr_in, .pad_oe_out, .pad_o_out, .pad_pullup_out,
   .alt_function_digital_input_out, .alt_function_analog_io_out);

// ### test/ppc_pad_model.sv
module ppc_pad_model #(parameter int WIDTH = 8) (
   input wire logic clk_in,
   input wire logic [WIDTH-1:0] oe_in, o_in, pu_in, xen_in, xv_in,
   output logic [WIDTH-1:0] level_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [WIDTH-1:0] fl_r = '0;
   // Undriven lines wander each cycle
   always @(posedge clk_in) fl_r <= ~fl_r;
   // Driver first, then outside source, then pull-up
   assign level_out = oe_in & o_in | ~oe_in & (xen_in & xv_in |
      ~xen_in & (pu_in | fl_r));
endmodule

// ### test/tb_top.sv
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
   logic sl = 1'b0;
   logic [3:0] addr_in = '0;
   logic [7:0] wd = '0, irq = '0, xen = '1, xv = '0, v, t, d, o;
   logic [7:0] rdat, oe, po, pu, di, alt_function_analog_io, lvl;
   ppc_pkg::ppc_ovr_t [7:0] ovr = '0, povr = '0;
   int bad_count = 0, checks_done = 0;
   ppc_port #(.WIDTH(8)) u_ppc_port (.clk_in, .rst_n_in, .addr_in,
      .wdata_in(wd), .wr_in, .rd_in, .rdata_out(rdat), .pad_level_in(lvl),
      .sleep_clamp_in(sl), .ext_irq_en_in(irq), .ovr_in(ovr),
      .pad_oe_out(oe), .pad_o_out(po), .pad_pullup_out(pu),
      .alt_function_digital_input_out(di), .alt_function_analog_io_out(alt_function_analog_io));
   ppc_pad_model #(.WIDTH(8)) u_ppc_pad_model (.clk_in, .oe_in(oe),
      .o_in(po), .pu_in(pu), .xen_in(xen), .xv_in(xv), .level_out(lvl));
   initial forever #20 clk_in = ~clk_in;
   task chk(input logic [7:0] s, e);
      checks_done++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %0t: %h not %h", $time, s, e);
      end
   endtask
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task wr(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk_in);
      addr_in <= a;
      wd <= x;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
   endtask
   task rd(input logic [3:0] a);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      @(negedge clk_in);
      v = rdat;
   endtask
   // Expected pull-ups from direction, out value and global disable
   function automatic logic [7:0] epu(input logic [7:0] d, o, input logic p);
      return p ? 8'h00 : ~d & o;
   endfunction
   // Expected driver enables with every direction bit clear
   function automatic logic [7:0] eoe(input ppc_pkg::ppc_ovr_t [7:0] w);
      logic [7:0] e;
      e = '0;
      for (int i = 0; i < 8; i++) e[i] = w[i].dir_en & w[i].dir_val;
      return e;
   endfunction
   // Watchdog
   initial begin
      #100us;
      bad_count++;
      complete_run;
   end
   initial begin
      v = 8'($urandom(32'hd808e283));
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      // Modes with the global pull-up disable both ways
      for (int k = 0; k < 8; k++) begin
         d = (k == 7) ? 8'hff : 8'($urandom);
         o = 8'($urandom);
         xv <= 8'($urandom);
         xen <= ~d;
         wr(4'h3, 8'(k % 2));
         // Direction first: each step passes a legal intermediate pair
         wr(4'h0, d);
         wr(4'h1, o);
         repeat (3) @(posedge clk_in);
         chk(oe, d);
         chk(po & d, o & d);
         chk(pu, epu(d, o, k[0]));
         rd(4'h2);
         chk(v, d & o | ~d & xv);
      end
      $display("test modes done");
      rd(4'h1);
      t = v;
      d = 8'($urandom);
      wr(4'h2, d);
      rd(4'h1);
      chk(v, t ^ d);
      @(posedge clk_in);
      ovr[0].tog_en <= 1'b1;
      @(posedge clk_in);
      ovr[0].tog_en <= 1'b0;
      rd(4'h1);
      chk(v, t ^ d ^ 8'h01);
      $display("test toggle done");
      // Pad change half way through a cycle
      wr(4'h0, 8'h00);
      xen <= '1;
      d = 8'($urandom);
      @(negedge clk_in);
      xv <= d;
      @(posedge clk_in);
      rd(4'h2);
      chk(v, d);
      // Pull-ups on, then reset in mid-run
      xen <= '0;
      wr(4'h3, 8'h00);
      wr(4'h1, 8'hff);
      repeat (2) @(posedge clk_in);
      chk(pu, 8'hff);
      rst_n_in <= 1'b0;
      @(negedge clk_in);
      chk(pu, 8'h00);
      chk(oe, 8'h00);
      repeat (4) @(posedge clk_in);
      rst_n_in <= 1'b1;
      xen <= '1;
      wr(4'h9, 8'hff);
      for (int a = 0; a < 2; a++) begin
         rd(4'(a));
         chk(v, 8'h00);
      end
      rd(4'h9);
      chk(v, 8'h00);
      $display("test reset done");
      // Random overrides, sleep and interrupt enables
      repeat (400) begin
         @(posedge clk_in);
         ovr <= 72'({$urandom, $urandom, $urandom});
         sl <= 1'($urandom);
         irq <= 8'($urandom);
         xv <= 8'($urandom);
         @(negedge clk_in);
         chk(oe, eoe(povr));
         povr = ovr;
      end
      @(posedge clk_in);
      ovr <= '0;
      $display("test random done");
      complete_run;
   end
endmodule
